// File: rtl/sysctrl_defines.vh
// Constants for the system-control register bank: offsets, masks, resets.
// Assumes a byte-addressed register port with word-aligned offsets.
`ifndef SYSCTRL_DEFINES_VH
`define SYSCTRL_DEFINES_VH

`define AW            7
`define OFS_IRQ_CLR   7'h00
`define OFS_IRQ_SET   7'h04
`define OFS_LOOP_VAL  7'h28
`define OFS_LOOP_MUL  7'h2c
`define OFS_LOOP_SYNC 7'h30
`define OFS_SUP_MON   7'h34
`define OFS_REGULATOR 7'h3c
`define OFS_VREF      7'h40

`define MSK_IRQ_EN    12'hfff
`define MSK_LOOP_VAL  32'hffffffff
`define MSK_LOOP_MUL  32'hffffffff
`define MSK_SUP_MON   32'h003ff35e
`define MSK_REGULATOR 32'h00002040
`define MSK_VREF      32'h07ff0003
`define MSK_BE_16     4'h3
`define MSK_BE_8      4'h1

`define RST_IRQ_EN    12'h000
`define RST_WORD      32'h00000000
`define RST_HALF      16'h0000

`define IRQ_N         12
`define BIT_LOOP_RDY  4
`define BIT_READ_REQ  7

// The 16 ns sync step spans 4 cycles of the 4 ns clock, counted down.
`define SYNC_CYC      3'h4
`define CNT_W         3
`define CNT_ZERO      3'h0
`define CNT_ONE       3'h1

`endif

// File: rtl/sysctrl_regs.v
// System-control register bank: interrupt enables, loop value and
// multiplier, read-sync request, supply monitor, regulator, reference.
// Assumes one requester that holds its request until ready_o pulses,
// and flag/status inputs that come from other clock domains.
//
// Function
// RL1: Accept 8, 16 and 32 bit accesses to 8, 16, 32 bit registers.
// RL2: Byte enables touch single bytes or halves, other bytes untouched.
// RL3: Only synchronized registers stall the bus for a sync step.
// RL4: Write-protectable registers ignore writes while protection is on.
// RL5: Enable clear register at offset zero, resets zero; zeros change nothing.
// RL6: Writing one to a clear bit disables that interrupt source.
// RL7: Enabled set flag raises a request; disabled flag raises none.
// RL8: Bits 11..8 supply monitor and loop stop; 7..0 loop and oscillators.
// RL9: Reading either enable register returns the shared enable state.
// RL10: Set register at offset four writes ones into the same enables.
// RL11: Loop ready source fires on rising edge of loop ready status.
// RL12: Reserved bits and offsets read zero and ignore writes.
`timescale 1ns/100ps
`include "sysctrl_defines.vh"

module sysctrl_regs
(
  input  wire        mclk_i,
  input  wire        arst_n_i,
  input  wire        sel_i,
  input  wire        we_i,
  input  wire [6:0]  addr_i,
  input  wire [3:0]  be_i,
  input  wire [31:0] wdata_i,
  input  wire        wprot_i,
  input  wire [11:0] irq_flag_i,
  input  wire        loop_ready_i,
  output reg  [31:0] rdata_o,
  output reg         ready_o,
  output reg         irq_o,
  output reg  [31:0] loop_value_o,
  output reg  [31:0] loop_multiplier_o,
  output reg  [31:0] supply_monitor_ctrl_o,
  output reg  [15:0] regulator_ctrl_o,
  output reg  [31:0] voltage_reference_ctrl_o
);

  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  reg  [11:0]        flag_meta_ff;
  reg  [11:0]        flag_ff;
  reg                lrdy_meta_ff;
  reg                lrdy_ff;
  reg                lrdy_dly_ff;
  reg  [11:0]        irq_en_ff;
  reg                state_ff;
  reg  [`CNT_W-1:0]  loop_cnt_ff;
  reg  [`CNT_W-1:0]  sup_cnt_ff;
  reg                loop_rd_ok_ff;
  reg                nxt_state;
  reg                nxt_ready;
  reg  [31:0]        nxt_rdata;
  reg  [11:0]        nxt_irq_en;
  reg  [`CNT_W-1:0]  nxt_loop_cnt;
  reg  [`CNT_W-1:0]  nxt_sup_cnt;
  reg                nxt_loop_rd_ok;
  reg  [31:0]        nxt_loop_val;
  reg  [31:0]        nxt_loop_mul;
  reg  [31:0]        nxt_sup_mon;
  reg  [15:0]        nxt_regulator;
  reg  [31:0]        nxt_vref;
  reg  [11:0]        src;
  reg                take;
  reg                wr;
  reg                rd;
  reg                stall;
  reg  [31:0]        dat;
  reg  [31:0]        reg_word;
  wire [31:0]        bmask;
  wire [31:0]        en_word;
  wire               loop_reg;
  wire               sup_busy;
  wire               loop_busy;

  // Expands byte enables into a bit mask, limited by the register width.
  function [31:0] lanes;
    input [3:0] be;
    input [3:0] width_be;
    reg   [3:0] b;
    begin
      b = be & width_be;
      lanes = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    end
  endfunction

  // Merges written lanes into a register, keeping reserved bits at zero.
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [31:0] lane;
    input [31:0] fmask;
    begin
      merge = ((old & ~lane) | (wd & lane)) & fmask;
    end
  endfunction

  assign bmask     = lanes(be_i, 4'hf); // RL1
  assign en_word   = {20'h00000, irq_en_ff}; // RL9
  assign loop_reg  = (addr_i == `OFS_LOOP_VAL) |
                     (addr_i == `OFS_LOOP_MUL);
  assign sup_busy  = (sup_cnt_ff != `CNT_ZERO);
  assign loop_busy = (loop_cnt_ff != `CNT_ZERO);

  always @*
  begin
    take           = sel_i & ~ready_o;
    wr             = 1'b0;
    rd             = 1'b0;
    stall          = 1'b0;
    dat            = `RST_WORD;
    reg_word       = `RST_WORD;
    nxt_state      = state_ff;
    nxt_ready      = 1'b0;
    nxt_rdata      = rdata_o;
    nxt_irq_en     = irq_en_ff;
    nxt_loop_cnt   = loop_busy ? loop_cnt_ff - `CNT_ONE : loop_cnt_ff;
    nxt_sup_cnt    = sup_busy ? sup_cnt_ff - `CNT_ONE : sup_cnt_ff;
    nxt_loop_rd_ok = loop_rd_ok_ff;
    nxt_loop_val   = loop_value_o;
    nxt_loop_mul   = loop_multiplier_o;
    nxt_sup_mon    = supply_monitor_ctrl_o;
    nxt_regulator  = regulator_ctrl_o;
    nxt_vref       = voltage_reference_ctrl_o;
    src            = flag_ff;
    // Loop ready requests only on its rising edge, not on the level.
    src[`BIT_LOOP_RDY] = lrdy_ff & ~lrdy_dly_ff; // RL11
    if (loop_cnt_ff == `CNT_ONE)
      nxt_loop_rd_ok = 1'b1;
    if (take)
    begin
      // Supply monitor access while its write sync runs must wait.
      if ((addr_i == `OFS_SUP_MON) & sup_busy)
        stall = 1'b1; // RL3
      // Loop reads wait for a read sync unless one already finished.
      if (loop_reg & ~we_i & lrdy_ff & (~loop_rd_ok_ff | loop_busy))
      begin
        stall = 1'b1; // RL3
        if (~loop_busy & ~loop_rd_ok_ff)
          nxt_loop_cnt = `SYNC_CYC;
      end
      nxt_state = stall ? ST_WAIT : ST_IDLE;
      wr        = we_i & ~stall;
      rd        = ~we_i & ~stall;
      nxt_ready = ~stall;
    end
    if (wr & ~wprot_i) // RL4
    begin
      case (addr_i)
        `OFS_IRQ_CLR:
          nxt_irq_en = irq_en_ff &
                       ~(wdata_i[11:0] & bmask[11:0]); // RL5 RL6
        `OFS_IRQ_SET:
          nxt_irq_en = irq_en_ff |
                       (wdata_i[11:0] & bmask[11:0]); // RL10
        `OFS_LOOP_VAL:
          if (lrdy_ff)
          begin
            nxt_loop_val   = merge(loop_value_o, wdata_i, bmask,
                                   `MSK_LOOP_VAL); // RL2
            nxt_loop_rd_ok = 1'b0;
          end
        `OFS_LOOP_MUL:
          if (lrdy_ff)
          begin
            nxt_loop_mul   = merge(loop_multiplier_o, wdata_i, bmask,
                                   `MSK_LOOP_MUL); // RL2
            nxt_loop_rd_ok = 1'b0;
          end
        `OFS_SUP_MON:
        begin
          nxt_sup_mon = merge(supply_monitor_ctrl_o, wdata_i, bmask,
                              `MSK_SUP_MON); // RL2
          nxt_sup_cnt = `SYNC_CYC; // RL3
        end
        `OFS_REGULATOR:
        begin
          // Only lanes 0 and 1 exist; the upper half is cut on purpose.
          reg_word      = merge({16'h0000, regulator_ctrl_o}, wdata_i,
                                lanes(be_i, `MSK_BE_16),
                                `MSK_REGULATOR); // RL2
          nxt_regulator = reg_word[15:0];
        end
        `OFS_VREF:
          nxt_vref = merge(voltage_reference_ctrl_o, wdata_i, bmask,
                           `MSK_VREF); // RL2
        default:
          nxt_state = ST_IDLE; // RL12
      endcase
    end
    // The read sync request is not under write protection.
    if (wr & (addr_i == `OFS_LOOP_SYNC) & be_i[0] &
        wdata_i[`BIT_READ_REQ] & ~loop_busy)
    begin
      nxt_loop_cnt   = `SYNC_CYC; // RL3
      nxt_loop_rd_ok = 1'b0;
    end
    if (rd)
    begin
      case (addr_i)
        `OFS_IRQ_CLR:   dat = en_word; // RL9
        `OFS_IRQ_SET:   dat = en_word; // RL10
        `OFS_LOOP_VAL:  dat = loop_value_o;
        `OFS_LOOP_MUL:  dat = loop_multiplier_o;
        `OFS_SUP_MON:   dat = supply_monitor_ctrl_o;
        `OFS_REGULATOR: dat = {16'h0000, regulator_ctrl_o};
        `OFS_VREF:      dat = voltage_reference_ctrl_o;
        default:        dat = `RST_WORD; // RL12
      endcase
      nxt_rdata = dat & bmask; // RL2
    end
    else if (take)
      nxt_rdata = `RST_WORD;
  end

  // Flag and status pins come from other clock domains: two flops each,
  // with the second flop feeding the logic; loop ready adds a third flop for edge detection.
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      flag_meta_ff <= `RST_IRQ_EN;
      flag_ff      <= `RST_IRQ_EN;
      lrdy_meta_ff <= 1'b0;
      lrdy_ff      <= 1'b0;
      lrdy_dly_ff  <= 1'b0;
    end
    else
    begin
      flag_meta_ff <= irq_flag_i;
      flag_ff      <= flag_meta_ff;
      lrdy_meta_ff <= loop_ready_i;
      lrdy_ff      <= lrdy_meta_ff;
      lrdy_dly_ff  <= lrdy_ff;
    end
  end

  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      irq_en_ff                <= `RST_IRQ_EN; // RL5
      state_ff                 <= ST_IDLE;
      loop_cnt_ff              <= `CNT_ZERO;
      sup_cnt_ff               <= `CNT_ZERO;
      loop_rd_ok_ff            <= 1'b0;
      rdata_o                  <= `RST_WORD;
      ready_o                  <= 1'b0;
      irq_o                    <= 1'b0;
      loop_value_o             <= `RST_WORD;
      loop_multiplier_o        <= `RST_WORD;
      supply_monitor_ctrl_o    <= `RST_WORD;
      regulator_ctrl_o         <= `RST_HALF;
      voltage_reference_ctrl_o <= `RST_WORD;
    end
    else
    begin
      irq_en_ff                <= nxt_irq_en & `MSK_IRQ_EN; // RL8
      state_ff                 <= nxt_state;
      loop_cnt_ff              <= nxt_loop_cnt;
      sup_cnt_ff               <= nxt_sup_cnt;
      loop_rd_ok_ff            <= nxt_loop_rd_ok;
      rdata_o                  <= nxt_rdata;
      ready_o                  <= nxt_ready;
      // Registered so the request pin is glitch free, at one cycle of delay.
      irq_o                    <= |(src & irq_en_ff); // RL7
      loop_value_o             <= nxt_loop_val;
      loop_multiplier_o        <= nxt_loop_mul;
      supply_monitor_ctrl_o    <= nxt_sup_mon;
      regulator_ctrl_o         <= nxt_regulator;
      voltage_reference_ctrl_o <= nxt_vref;
    end
  end

endmodule // sysctrl_regs

// File: verification/sysctrl_regs_chk.sv
// Port checker for the system-control register bank.
// Assumes requests are held until ready_o and wprot_i stays steady.
`timescale 1ns/100ps
module sysctrl_regs_chk
(
  input logic        mclk_i,
  input logic        arst_n_i,
  input logic        sel_i,
  input logic        we_i,
  input logic [6:0]  addr_i,
  input logic [3:0]  be_i,
  input logic [31:0] wdata_i,
  input logic        wprot_i,
  input logic [11:0] irq_flag_i,
  input logic        loop_ready_i,
  input logic [31:0] rdata_o,
  input logic        ready_o,
  input logic        irq_o,
  input logic [31:0] loop_value_o,
  input logic [31:0] loop_multiplier_o,
  input logic [31:0] supply_monitor_ctrl_o,
  input logic [15:0] regulator_ctrl_o,
  input logic [31:0] voltage_reference_ctrl_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  ready_pulse_a: assert property
    (ready_o |=> !ready_o)
    else $error("ready held longer than one cycle");
  ready_bound_a: assert property
    (sel_i && !ready_o |-> ##[1:8] ready_o)
    else $error("access not answered in time");
  lane_mask_a: assert property
    (ready_o && !we_i && be_i == 4'h1 |-> rdata_o[31:8] == 24'h000000)
    else $error("unselected lanes read nonzero");
  half_keep_a: assert property
    (sel_i && we_i && addr_i == 7'h28 && be_i[3:2] == 2'h0
      |=> $stable(loop_value_o[31:16]))
    else $error("unselected lanes written");
  prot_write_a: assert property
    (sel_i && we_i && wprot_i && addr_i == 7'h3c
      |=> $stable(regulator_ctrl_o))
    else $error("protected write took effect");
  enable_bits_a: assert property
    (ready_o && !we_i && addr_i == 7'h00 |-> rdata_o[31:12] == 20'h00000)
    else $error("reserved enable bits nonzero");
  reserved_read_a: assert property
    (ready_o && !we_i && (addr_i == 7'h38 || addr_i == 7'h30)
      |-> rdata_o == 32'h00000000)
    else $error("reserved place read nonzero");
  irq_quiet_a: assert property
    ((irq_flag_i == 12'h000 && !loop_ready_i) [*4] |=> !irq_o)
    else $error("request without a flag");
  cover property (ready_o && we_i);
  cover property (ready_o && !we_i);
  cover property ($rose(irq_o));
  cover property (sel_i && we_i && wprot_i);
endmodule // sysctrl_regs_chk

bind sysctrl_regs sysctrl_regs_chk chk_u (.mclk_i(mclk_i),
  .arst_n_i(arst_n_i),
  .sel_i(sel_i), .we_i(we_i), .addr_i(addr_i), .be_i(be_i), .wdata_i(wdata_i),
  .wprot_i(wprot_i), .irq_flag_i(irq_flag_i), .loop_ready_i(loop_ready_i),
  .rdata_o(rdata_o), .ready_o(ready_o), .irq_o(irq_o),
  .loop_value_o(loop_value_o), .loop_multiplier_o(loop_multiplier_o),
  .supply_monitor_ctrl_o(supply_monitor_ctrl_o),
  .regulator_ctrl_o(regulator_ctrl_o),
  .voltage_reference_ctrl_o(voltage_reference_ctrl_o));

// File: verification/sysctrl_regs_tb.sv
// Self-checking bench for the system-control register bank.
// Assumes nothing else; the bench is the only bus requester.
`timescale 1ns/100ps
module sysctrl_regs_tb;
  typedef struct packed
  {
    logic        we;
    logic [6:0]  a;
    logic [3:0]  be;
    logic [31:0] d;
  } row_t;
  logic        mclk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        sel_i = 1'b0;
  logic        we_i = 1'b0;
  logic [6:0]  addr_i = 7'h00;
  logic [3:0]  be_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic        wprot_i = 1'b0;
  logic [11:0] irq_flag_i = 12'h000;
  logic        loop_ready_i = 1'b1;
  wire  [31:0] rdata_o;
  wire         ready_o;
  wire         irq_o;
  wire  [31:0] loop_value_o;
  wire  [31:0] loop_multiplier_o;
  wire  [31:0] supply_monitor_ctrl_o;
  wire  [15:0] regulator_ctrl_o;
  wire  [31:0] voltage_reference_ctrl_o;
  logic [31:0] rd;
  logic        seen;
  int          error_cnt = 0;
  int          checks_done = 0;
  // Reads carry the expected data in d; rows follow each other in order.
  row_t rows [23] = '{'{0,7'h00,4'hf,32'h0}, '{1,7'h04,4'hf,32'hfff},
    '{0,7'h00,4'hf,32'hfff}, '{1,7'h00,4'hf,32'h0}, '{0,7'h00,4'hf,32'hfff},
    '{1,7'h00,4'h2,32'hfff}, '{0,7'h00,4'hf,32'h0ff},
    '{0,7'h04,4'hf,32'h0ff},
    '{1,7'h2c,4'hf,32'h12345678}, '{0,7'h2c,4'h1,32'h78},
    '{1,7'h28,4'h2,32'haabbccdd}, '{0,7'h28,4'hf,32'hcc00},
    '{1,7'h3c,4'hf,32'hffffffff}, '{0,7'h3c,4'hf,32'h2040},
    '{1,7'h34,4'hf,32'hffffffff}, '{0,7'h34,4'hf,32'h3ff35e},
    '{1,7'h30,4'h1,32'h80}, '{0,7'h30,4'hf,32'h0}, '{0,7'h38,4'hf,32'h0},
    '{1,7'h40,4'hf,32'hffffffff}, '{0,7'h40,4'hf,32'h07ff0003},
    '{1,7'h40,4'h3,32'h0}, '{0,7'h40,4'hf,32'h07ff0000}};
  always #2 mclk_i = ~mclk_i;
  sysctrl_regs dut_u (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .sel_i(sel_i),
    .we_i(we_i), .addr_i(addr_i), .be_i(be_i), .wdata_i(wdata_i),
    .wprot_i(wprot_i), .irq_flag_i(irq_flag_i), .loop_ready_i(loop_ready_i),
    .rdata_o(rdata_o), .ready_o(ready_o), .irq_o(irq_o),
    .loop_value_o(loop_value_o), .loop_multiplier_o(loop_multiplier_o),
    .supply_monitor_ctrl_o(supply_monitor_ctrl_o),
    .regulator_ctrl_o(regulator_ctrl_o),
    .voltage_reference_ctrl_o(voltage_reference_ctrl_o));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // The request stands through the edge that samples ready_o high.
  task automatic xfer(input row_t r);
    int n;
    n = 0;
    @(posedge mclk_i);
    #1;
    sel_i = 1'b1;
    we_i = r.we;
    addr_i = r.a;
    be_i = r.be;
    wdata_i = r.d;
    do
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    while (ready_o !== 1'b1 && n < 20);
    if (n >= 20)
      chk(32'h1, 32'h0);
    rd = rdata_o;
    @(posedge mclk_i);
    #1;
    sel_i = 1'b0;
  endtask
  task automatic settle;
    repeat (6) @(posedge mclk_i);
    #1;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge mclk_i);
    #1;
    arst_n_i = 1'b1;
    foreach (rows[i])
    begin
      xfer(rows[i]);
      if (!rows[i].we)
        chk(rd, rows[i].d);
    end
    $display("register table done");
    chk(loop_multiplier_o, 32'h12345678);
    chk(loop_value_o, 32'h0000cc00);
    chk(supply_monitor_ctrl_o, 32'h003ff35e);
    chk({16'h0000, regulator_ctrl_o}, 32'h00002040);
    chk(voltage_reference_ctrl_o, 32'h07ff0000);
    irq_flag_i = 12'h001;
    settle;
    chk({31'h0, irq_o}, 32'h1);
    xfer(row_t'{1, 7'h00, 4'hf, 32'h1});
    settle;
    chk({31'h0, irq_o}, 32'h0);
    irq_flag_i = 12'h000;
    wprot_i = 1'b1;
    xfer(row_t'{1, 7'h3c, 4'hf, 32'h0});
    wprot_i = 1'b0;
    chk({16'h0000, regulator_ctrl_o}, 32'h00002040);
    xfer(row_t'{0, 7'h3c, 4'hf, 32'h0});
    chk(rd, 32'h2040);
    $display("enable and protection done");
    loop_ready_i = 1'b0;
    settle;
    chk({31'h0, irq_o}, 32'h0);
    loop_ready_i = 1'b1;
    seen = 1'b0;
    repeat (8)
    begin
      @(posedge mclk_i);
      #1;
      seen = seen | (irq_o === 1'b1);
    end
    chk({31'h0, seen}, 32'h1);
    $display("loop ready event done");
    irq_flag_i = 12'h002;
    settle;
    chk({31'h0, irq_o}, 32'h1);
    arst_n_i = 1'b0;
    settle;
    chk({31'h0, irq_o}, 32'h0);
    arst_n_i = 1'b1;
    xfer(row_t'{0, 7'h00, 4'hf, 32'h0});
    chk(rd, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    irq_flag_i = 12'h000;
    $display("reset done");
    summarize;
  end
  // The 27 transfers of at most 8 cycles each fit well inside this span.
  initial
  begin
    #20000;
    error_cnt++;
    summarize;
  end
endmodule // sysctrl_regs_tb
